// >>> flash_ctl_defines.svh
// constants for the on-chip flash sequencer
// assumes a 10 MHz system clock and a 32-bit word path
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

`define CLK_NS 100
`define PAGE_WORDS 64
`define PAGE_PROG_NS 1250000
`define BLOCK_ERASE_NS 100000000
`define RST_READ_NS 2000000
`define WORD_ADDR_W 15
`define BLK0_END 15'h3fff
`define BLK1_END 15'h5fff
`define BLK2_END 15'h6fff
`define UNLOCK1_ADDR 15'h0555
`define UNLOCK2_ADDR 15'h02aa
`define UNLOCK1_DATA 8'haa
`define UNLOCK2_DATA 8'h55
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_BLOCK_ERASE 8'h30
`define CMD_PROTECT 8'h60
`define CMD_READ_PROTECT 8'h70
`define CMD_RESET 8'hf0
`define ERASED_WORD 32'hffffffff
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define DONE_BIT 5
`define NUM_BLOCKS 4
`define BOOT_SYNC_EDGES 2'h2

`endif

// >>> flash_ctl_pkg.sv
// types shared by the flash sequencer files
// expects flash_ctl_defines.svh for the numeric constants
package flash_ctl_pkg;
    typedef enum logic [2:0] {
        st_ready = 3'h0,
        st_unlock1 = 3'h1,
        st_unlock2 = 3'h2,
        st_cmd = 3'h3,
        st_load = 3'h4,
        st_busy = 3'h5,
        st_recover = 3'h6
    } seq_state_e;

    typedef enum logic [1:0] {
        op_none = 2'h0,
        op_page = 2'h1,
        op_block = 2'h2,
        op_chip = 2'h3
    } op_kind_e;
endpackage

// >>> pin_sync.sv
// two-flop synchroniser for a pin input
// assumes one system clock; reset value is a parameter
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic pin,
    output logic level
);
    logic meta_q;
    logic meta_d;
    logic level_q;
    logic level_d;

    always_comb begin
        meta_d = clk_en ? pin : meta_q;
        level_d = clk_en ? meta_q : level_q;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule

// >>> flash_ctl.sv
// on-chip flash array with automatic program and erase sequencer
// assumes the cpu bus issues one access per cycle and waits on rd_valid
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
// Notes on behaviour
// - programming is done a page at a time, 64 words per page
// - page program takes 1.25 ms regardless of words loaded
// - one block erase takes 0.1 s
// - cpu reads and writes the array 32 bits wide
// - blocks of 64, 32, 16 and 16 KB, 128 KB total
// - standard unlock command set; polling and toggle bits show progress
// - erase cannot be suspended or resumed
// - block protection set only by software command, no high-voltage pin
// - read protection blocks external programming tools from reading array
// - boot pin sampled just after reset release; high single chip, low single boot
// - single chip mode starts execution from the flash array
// - single boot mode starts execution from the boot rom
// - clock gear is 1/1 after reset
// - after reset interrupts an operation, array readable only after 2 ms
// - no array data returned while an operation runs
module flash_ctl
    import flash_ctl_pkg::*;
#(
    parameter int PAGE_PROG_CYC = (`PAGE_PROG_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int BLOCK_ERASE_CYC = (`BLOCK_ERASE_NS + `CLK_NS - 1) / `CLK_NS,
    parameter int RST_READ_CYC = (`RST_READ_NS + `CLK_NS - 1) / `CLK_NS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic port_h_bit_zero,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`WORD_ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic ext_tool_access,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic busy,
    output logic single_boot,
    output logic boot_from_rom,
    output logic [1:0] clock_gear,
    output logic [`NUM_BLOCKS-1:0] block_protected,
    output logic read_protected
);
    localparam int DEPTH = 1 << `WORD_ADDR_W;
    localparam int PW = $clog2(`PAGE_WORDS);

    logic [31:0] mem [DEPTH];
    logic [31:0] page_buf [`PAGE_WORDS];

    logic boot_lvl;
    seq_state_e state_q, state_d;
    op_kind_e op_q, op_d;
    logic [26:0] cnt_q, cnt_d;
    logic [PW:0] nload_q, nload_d;
    logic [`WORD_ADDR_W-1:0] base_q, base_d;
    logic [1:0] blk_q, blk_d;
    logic toggle_q, toggle_d;
    logic [`NUM_BLOCKS-1:0] prot_q, prot_d;
    logic rprot_q, rprot_d;
    logic boot_q, boot_d;
    logic [1:0] boot_wait_q, boot_wait_d;
    logic [31:0] rd_q, rd_d;
    logic rv_q, rv_d;
    logic commit;
    logic [1:0] blk_of_addr;
    logic [7:0] cmd;

    // pin crosses two flops; captured once after release, held until the next reset
    pin_sync #(.RESET_VAL(1'b1)) u_boot_sync (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin(port_h_bit_zero),
        .level(boot_lvl)
    );

    assign cmd = wr_data[7:0];

    always_comb begin
        // block map: 64 KB, 32 KB, 16 KB, 16 KB in 32-bit words
        if (addr <= `BLK0_END) blk_of_addr = 2'd0;
        else if (addr <= `BLK1_END) blk_of_addr = 2'd1;
        else if (addr <= `BLK2_END) blk_of_addr = 2'd2;
        else blk_of_addr = 2'd3;
    end

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        nload_d = nload_q;
        base_d = base_q;
        blk_d = blk_q;
        toggle_d = toggle_q;
        prot_d = prot_q;
        rprot_d = rprot_q;
        boot_d = boot_q;
        boot_wait_d = boot_wait_q;
        rd_d = rd_q;
        rv_d = 1'b0;
        commit = 1'b0;
        // synchroniser shows its reset value for two edges; latch the pin after that
        if (boot_wait_q == `BOOT_SYNC_EDGES) boot_d = boot_lvl;
        if (boot_wait_q <= `BOOT_SYNC_EDGES) boot_wait_d = boot_wait_q + 2'h1;
        case (state_q)
            st_ready: begin
                if (wr_en && addr == `UNLOCK1_ADDR && cmd == `UNLOCK1_DATA) begin
                    state_d = st_unlock1;
                end
            end
            st_unlock1: begin
                if (wr_en) begin
                    state_d = (addr == `UNLOCK2_ADDR && cmd == `UNLOCK2_DATA) ?
                        st_unlock2 : st_ready;
                end
            end
            st_unlock2: begin
                if (wr_en) begin
                    state_d = st_ready;
                    if (cmd == `CMD_PROGRAM) begin
                        state_d = st_load;
                        nload_d = '0;
                    end else if (cmd == `CMD_ERASE_SETUP) begin
                        state_d = st_cmd;
                    end else if (cmd == `CMD_PROTECT) begin
                        prot_d[blk_of_addr] = 1'b1;
                    end else if (cmd == `CMD_READ_PROTECT) begin
                        rprot_d = 1'b1;
                    end
                end
            end
            st_cmd: begin
                // second unlock pair is folded: next write names the erase
                if (wr_en) begin
                    state_d = st_ready;
                    if (cmd == `CMD_CHIP_ERASE && prot_q == '0) begin
                        op_d = op_chip;
                        cnt_d = 27'(BLOCK_ERASE_CYC * `NUM_BLOCKS);
                        state_d = st_busy;
                    end else if (cmd == `CMD_BLOCK_ERASE && !prot_q[blk_of_addr]) begin
                        op_d = op_block;
                        blk_d = blk_of_addr;
                        cnt_d = 27'(BLOCK_ERASE_CYC);
                        state_d = st_busy;
                    end
                end
            end
            st_load: begin
                // one page, up to 64 words; start on a 0xf0 reset-command write or when the 64th word lands
                if (wr_en) begin
                    if (nload_q == '0) base_d = {addr[`WORD_ADDR_W-1:PW], PW'(0)};
                    if (cmd == `CMD_RESET && wr_data[31:8] == '0 && nload_q != '0) begin
                        op_d = prot_q[blk_of_addr] ? op_none : op_page;
                        cnt_d = 27'(PAGE_PROG_CYC); // fixed, not word count based
                        state_d = st_busy;
                    end else begin
                        nload_d = nload_q + 1'b1;
                        if (nload_q == (PW+1)'(`PAGE_WORDS - 1)) begin
                            op_d = prot_q[blk_of_addr] ? op_none : op_page;
                            cnt_d = 27'(PAGE_PROG_CYC);
                            state_d = st_busy;
                        end
                    end
                end
            end
            st_busy: begin
                // writes ignored: no suspend or resume path
                cnt_d = cnt_q - 1'b1;
                if (rd_en) toggle_d = ~toggle_q;
                if (cnt_q == 27'd1) begin
                    commit = 1'b1;
                    state_d = st_ready;
                    op_d = op_none;
                end
            end
            st_recover: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == 27'd1) state_d = st_ready;
            end
            default: state_d = st_ready;
        endcase
        if (rd_en) begin
            rv_d = 1'b1;
            if (state_q == st_busy || state_q == st_recover) begin
                // status word instead of array data
                rd_d = '0;
                rd_d[`POLL_BIT] = 1'b0;
                rd_d[`TOGGLE_BIT] = ~toggle_q;
            end else if (rprot_q && ext_tool_access) begin
                rd_d = '0;
            end else begin
                rd_d = mem[addr];
            end
        end
    end

    // array and page buffer written without reset; contents survive reset
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (state_q == st_load && wr_en) page_buf[nload_q[PW-1:0]] <= wr_data;
            if (commit) begin
                for (int i = 0; i < DEPTH; i++) begin
                    if (op_q == op_chip ||
                        (op_q == op_block && blk_q == (i <= `BLK0_END ? 2'd0 :
                            i <= `BLK1_END ? 2'd1 : i <= `BLK2_END ? 2'd2 : 2'd3)))
                        mem[i] <= `ERASED_WORD;
                end
                if (op_q == op_page) begin
                    for (int j = 0; j < `PAGE_WORDS; j++) begin
                        if (j < nload_q) mem[base_q + `WORD_ADDR_W'(j)] <=
                            mem[base_q + `WORD_ADDR_W'(j)] & page_buf[j];
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // every reset waits out a possible interrupted operation
            state_q <= st_recover;
            op_q <= op_none;
            cnt_q <= 27'(RST_READ_CYC);
            nload_q <= '0;
            base_q <= '0;
            blk_q <= '0;
            toggle_q <= 1'b0;
            prot_q <= '0;
            rprot_q <= 1'b0;
            boot_q <= 1'b1;
            boot_wait_q <= '0;
            rd_q <= '0;
            rv_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            nload_q <= nload_d;
            base_q <= base_d;
            blk_q <= blk_d;
            toggle_q <= toggle_d;
            prot_q <= prot_d;
            rprot_q <= rprot_d;
            boot_q <= boot_d;
            boot_wait_q <= boot_wait_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
        end
    end

    assign rd_data = rd_q;
    assign rd_valid = rv_q;
    assign busy = (state_q == st_busy) || (state_q == st_recover);
    assign single_boot = ~boot_q;
    assign boot_from_rom = ~boot_q;
    assign clock_gear = 2'h0; // 1/1 ratio
    assign block_protected = prot_q;
    assign read_protected = rprot_q;
endmodule

// >>> flash_ctl_monitor.sv
// port assertions for the flash sequencer
// bound to flash_ctl; one clock domain, clk_en kept high
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
module flash_ctl_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic busy,
    input wire logic single_boot,
    input wire logic boot_from_rom,
    input wire logic [1:0] clock_gear,
    input wire logic [`NUM_BLOCKS-1:0] block_protected,
    input wire logic read_protected
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence read_taken;
        rd_en && clk_en;
    endsequence
    sequence status_word;
        rd_valid && rd_data[31:7] == 25'h0 && rd_data[5:0] == 6'h0;
    endsequence
    sequence op_launch;
        !busy ##1 busy;
    endsequence
    read_answer_a: assert property (read_taken |=> rd_valid)
        else $error("read not answered next cycle");
    read_cause_a: assert property (rd_valid |-> $past(rd_en && clk_en))
        else $error("read valid without a read");
    busy_status_a: assert property (read_taken and busy |=> status_word)
        else $error("array data returned while busy");
    busy_start_a: assert property ($rose(busy) |-> $past(wr_en))
        else $error("busy rose without a write");
    busy_hold_a: assert property (op_launch |=> busy [*8])
        else $error("operation ended too early");
    gear_undivided_a: assert property (clock_gear == 2'h0)
        else $error("clock gear not undivided");
    rom_boot_a: assert property (boot_from_rom == single_boot)
        else $error("boot source disagrees with mode");
    boot_stable_a: assert property ($changed(single_boot) |-> busy)
        else $error("boot mode changed outside reset recovery");
    prot_sticky_a: assert property ((block_protected & $past(block_protected))
        == $past(block_protected))
        else $error("block protection dropped");
    rdprot_sticky_a: assert property (!$fell(read_protected))
        else $error("read protection dropped");
endmodule
bind flash_ctl flash_ctl_monitor mon (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .single_boot(single_boot), .boot_from_rom(boot_from_rom), .clock_gear(clock_gear),
    .block_protected(block_protected), .read_protected(read_protected));

// >>> cpu_model.sv
// cpu bus master issuing flash writes, commands and reads
// drives at the falling edge; runs from ram, never fetches from the array
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
module cpu_model (
    input wire logic clock,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    output logic wr_en,
    output logic rd_en,
    output logic [`WORD_ADDR_W-1:0] addr,
    output logic [31:0] wr_data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 15'h0;
        wr_data = 32'h0;
    end
    // released bus shows inverted values so stale ones never look valid
    task automatic wr(input logic [14:0] a, input logic [31:0] v);
        @(negedge clock);
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
        addr = ~a;
        wr_data = ~v;
    endtask
    task automatic rd(input logic [14:0] a, output logic [31:0] v);
        @(negedge clock);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        addr = ~a;
        v = rd_valid ? rd_data : 32'hx;
    endtask
    // no interrupts are raised while a rewrite runs
    task automatic cmd(input logic [7:0] c, input logic [14:0] a);
        wr(`UNLOCK1_ADDR, {24'h0, `UNLOCK1_DATA});
        wr(`UNLOCK2_ADDR, {24'h0, `UNLOCK2_DATA});
        wr(a, {24'h0, c});
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for flash_ctl with shortened timings
// uses cpu_model as bus master; clk_en held high
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
module testbench;
    localparam int PP = 20;
    localparam int BE = 50;
    localparam int RR = 10;
    localparam logic [31:0] W0 = 32'h1234abcd;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pin = 1'b1;
    logic ext = 1'b0;
    logic wr_en, rd_en, rd_valid, busy, single_boot, boot_from_rom, read_protected;
    logic [14:0] addr;
    logic [31:0] wr_data, rd_data, d, e;
    logic [1:0] clock_gear;
    logic [3:0] block_protected;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int s;
    always #50 clock = ~clock;
    flash_ctl #(.PAGE_PROG_CYC(PP), .BLOCK_ERASE_CYC(BE), .RST_READ_CYC(RR)) dut (
        .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .port_h_bit_zero(pin),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
        .ext_tool_access(ext), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
        .single_boot(single_boot), .boot_from_rom(boot_from_rom),
        .clock_gear(clock_gear), .block_protected(block_protected),
        .read_protected(read_protected));
    cpu_model m (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pin held through reset and the latch cycles after release
    task automatic hw_reset(input logic lvl, input int n);
        @(negedge clock);
        reset_n = 1'b0;
        pin = lvl;
        repeat (n) @(negedge clock);
        reset_n = 1'b1;
        s = cyc;
        repeat (3) @(negedge clock);
    endtask
    // a hang here is caught by the cycle ceiling
    task automatic wait_idle();
        while (busy !== 1'b0) @(negedge clock);
    endtask
    task automatic erase(input logic [14:0] a);
        m.cmd(`CMD_ERASE_SETUP, `UNLOCK1_ADDR);
        m.wr(a, {24'h0, `CMD_BLOCK_ERASE});
    endtask
    task automatic t_boot();
        check("single_boot", 0, single_boot);
        check("boot_from_rom", 0, boot_from_rom);
        check("clock_gear", 0, clock_gear);
        m.rd(15'h100, d);
        check("recovery status", 0, d & 32'hffffffbf);
        wait_idle();
        // array powers up unknown; chip erase gives a known start
        m.cmd(`CMD_ERASE_SETUP, `UNLOCK1_ADDR);
        m.wr(`UNLOCK1_ADDR, {24'h0, `CMD_CHIP_ERASE});
        s = cyc;
        check("chip busy", 1, busy);
        wait_idle();
        check("chip time", 1, (cyc - s) inside {[4*BE-1:4*BE+1]});
        m.rd(15'h100, d);
        check("erased word", `ERASED_WORD, d);
        $display("boot test done");
    endtask
    task automatic t_prog();
        m.cmd(`CMD_PROGRAM, `UNLOCK1_ADDR);
        m.wr(15'h100, W0);
        m.wr(15'h101, 32'h0f0f5a5a);
        m.wr(15'h102, {24'h0, `CMD_RESET});
        s = cyc;
        check("busy", 1, busy);
        m.rd(15'h100, d);
        m.rd(15'h100, e);
        check("status bits", 0, d & 32'hffffffbf);
        check("toggle", 32'h40, d ^ e);
        wait_idle();
        check("page time", 1, (cyc - s) inside {[PP-1:PP+1]});
        m.rd(15'h100, d);
        check("word 0", W0, d);
        m.rd(15'h101, d);
        check("word 1", 32'h0f0f5a5a, d);
        m.rd(15'h102, d);
        check("unloaded word", `ERASED_WORD, d);
        $display("program test done");
    endtask
    task automatic t_prot();
        m.cmd(`CMD_PROTECT, 15'h0);
        @(negedge clock);
        check("protect bits", 4'h1, block_protected);
        erase(15'h0);
        check("erase refused", 0, busy);
        m.cmd(`CMD_ERASE_SETUP, `UNLOCK1_ADDR);
        m.wr(`UNLOCK1_ADDR, {24'h0, `CMD_CHIP_ERASE});
        check("chip refused", 0, busy);
        m.rd(15'h100, d);
        check("kept", W0, d);
        $display("protect test done");
    endtask
    task automatic t_erase();
        erase(15'h4000);
        s = cyc;
        m.wr(`UNLOCK1_ADDR, 32'hb0);
        check("no suspend", 1, busy);
        wait_idle();
        check("erase time", 1, (cyc - s) inside {[BE-1:BE+1]});
        m.rd(15'h100, d);
        check("other block", W0, d);
        $display("erase test done");
    endtask
    task automatic t_rprot();
        m.cmd(`CMD_READ_PROTECT, `UNLOCK1_ADDR);
        @(negedge clock);
        check("read protect", 1, read_protected);
        ext = 1'b1;
        m.rd(15'h100, d);
        ext = 1'b0;
        check("tool read hidden", 1, d !== W0);
        m.rd(15'h100, d);
        check("cpu read", W0, d);
        $display("read protect test done");
    endtask
    task automatic t_rst();
        erase(15'h4000);
        repeat (3) @(negedge clock);
        hw_reset(1'b0, 5);
        check("single_boot", 1, single_boot);
        check("boot_from_rom", 1, boot_from_rom);
        check("busy", 1, busy);
        wait_idle();
        check("recovery", 1, (cyc - s) inside {[RR-1:RR+2]});
        m.rd(15'h100, d);
        check("after reset", W0, d);
        $display("mid-run reset test done");
    endtask
    initial begin
        hw_reset(1'b1, 20);
        t_boot();
        t_prog();
        t_prot();
        t_erase();
        t_rprot();
        t_rst();
        complete_run();
    end
endmodule
